// File: shared/ccb_regs.svh
`ifndef CCB_REGS_SVH
`define CCB_REGS_SVH

// Clock and timing figures.
`define CCB_CLK_NS        10
`define CCB_RECALL_MS     500
`define CCB_STORE_NS      2000
`define CCB_TX_BIT_NS     8000
`define CCB_REF_INC       16'h51EC

// Decoded address ranges, inclusive bounds.
`define CCB_MON_LO        16'h0000
`define CCB_MON_HI        16'h0FFF
`define CCB_WORK_LO       16'h2000
`define CCB_WORK_HI       16'h3FFF
`define CCB_SHARED_LO     16'h4000
`define CCB_SHARED_HI     16'h47FF
`define CCB_IO_LO         16'h4800
`define CCB_IO_HI         16'h48FF
`define CCB_PROG_LO       16'h8000
`define CCB_PROG_HI       16'hFFFF

// Port addresses inside the I/O range.
`define CCB_IO_RX0        16'h4800
`define CCB_IO_RX1        16'h4802
`define CCB_IO_TXDATA     16'h4804
`define CCB_IO_TXCTRL     16'h4806

// Fields of port words.
`define CCB_RX_DATA_BIT   0
`define CCB_RX_FRAME_BIT  1
`define CCB_TX_DATA_BIT   0
`define CCB_TX_EN_BIT     0

// Interrupt vectors.
`define CCB_VEC_RX0       16'h0010
`define CCB_VEC_RX1       16'h0014
`define CCB_VEC_TX        16'h0018
`define CCB_VEC_NONE      16'h0000

// Interrupt source indices, lower index wins.
`define CCB_SRC_RX0       0
`define CCB_SRC_RX1       1
`define CCB_SRC_TX        2

`endif

// File: shared/ccb_pkg.sv
package ccb_pkg;
  typedef enum logic [1:0] {
    TX_OFF,
    TX_READY,
    TX_SEND
  } ccb_tx_state_t;
  typedef logic [15:0] ccb_word_t;
endpackage

// File: src/ccb_rx_port.sv
`timescale 1ns/1ns
`include "ccb_regs.svh"

// One uplink receiver input port; it never disarms.
module ccb_rx_port (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic bit_clk_in,
  input  wire logic frame_in,
  input  wire logic data_in,
  output logic      bit_out,
  output logic      frame_out,
  output logic      req_out
);
  logic [1:0] clk_s_q;
  logic [1:0] frm_s_q;
  logic [1:0] dat_s_q;
  logic       clk_prev_q;
  logic       edge_w;

  always_ff @(posedge core_clk_in) begin
    clk_s_q <= {clk_s_q[0], bit_clk_in};
    frm_s_q <= {frm_s_q[0], frame_in};
    dat_s_q <= {dat_s_q[0], data_in};
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s_q[1];
    end
  end

  assign edge_w = clk_s_q[1] & ~clk_prev_q;

  // Data and frame marker are taken together on the bit clock edge.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      bit_out   <= 1'b0;
      frame_out <= 1'b0;
      req_out   <= 1'b0;
    end else begin
      req_out <= edge_w;
      if (edge_w) begin
        bit_out   <= dat_s_q[1];
        frame_out <= frm_s_q[1];
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  capture_bit_a: assert property (edge_w |=> bit_out == $past(dat_s_q[1]) && frame_out == $past(frm_s_q[1]))
    else $error("Captured bit or frame marker does not match the line.");
  one_req_a: assert property (req_out |=> !req_out)
    else $error("Bit request longer than one cycle.");
endmodule

// File: src/ccb_power_seq.sv
`timescale 1ns/1ns
`include "ccb_regs.svh"

// Recall pulse after reset and store pulse on a falling supply.
module ccb_power_seq #(
  parameter int RECALL_CYC = (`CCB_RECALL_MS * 1000000) / `CCB_CLK_NS
) (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic supply_low_in,
  output logic      store_out,
  output logic      recall_out
);
  localparam int STORE_CYC = (`CCB_STORE_NS + `CCB_CLK_NS - 1) / `CCB_CLK_NS;

  logic [1:0]  low_s_q;
  logic        low_prev_q;
  logic [25:0] recall_cnt_q;
  logic [7:0]  store_cnt_q;

  always_ff @(posedge core_clk_in) begin
    low_s_q <= {low_s_q[0], supply_low_in};
  end

  // Reset stands in for power-up here; the pulse runs from its release.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      recall_cnt_q <= 26'h0000000;
      recall_out   <= 1'b1;
    end else if (recall_out) begin
      if (recall_cnt_q == 26'(RECALL_CYC - 1)) begin
        recall_out <= 1'b0;
      end
      recall_cnt_q <= recall_cnt_q + 26'h0000001;
    end
  end

  // A drop seen during recall is ignored, so settling noise never saves garbage.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      low_prev_q  <= 1'b1;
      store_cnt_q <= 8'h00;
      store_out   <= 1'b0;
    end else begin
      low_prev_q <= low_s_q[1];
      if (recall_out) begin
        store_out   <= 1'b0;
        store_cnt_q <= 8'h00;
      end else if (store_out) begin
        if (store_cnt_q == 8'(STORE_CYC - 1)) begin
          store_out <= 1'b0;
        end
        store_cnt_q <= store_cnt_q + 8'h01;
      end else if (low_s_q[1] && !low_prev_q) begin
        store_out   <= 1'b1;
        store_cnt_q <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  store_blocked_a: assert property (recall_out |-> !store_out)
    else $error("Store pulse while recall active.");
  recall_start_a: assert property ($fell(srst_in) |-> recall_out [*8])
    else $error("Recall pulse did not start after reset.");
  store_start_a: assert property (!recall_out && !store_out && low_s_q[1] && !low_prev_q |=> store_out)
    else $error("Supply drop did not start a store pulse.");
endmodule

// File: src/ccb_comm_card.sv
`timescale 1ns/1ns
`include "ccb_regs.svh"

module ccb_comm_card #(
  parameter int RECALL_CYC = (`CCB_RECALL_MS * 1000000) / `CCB_CLK_NS
) (
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic             ad_oe_out,
  input  wire logic        as_n_in,
  input  wire logic        ds_n_in,
  input  wire logic        read_in,
  input  wire logic        iack_in,
  output logic             irq_out,
  output logic             cs_mon_rom_out,
  output logic             cs_work_ram_out,
  output logic             cs_prog_rom_out,
  output logic             cs_shared_ram_out,
  input  wire logic [1:0]  rx_bit_clk_in,
  input  wire logic [1:0]  rx_frame_in,
  input  wire logic [1:0]  rx_data_in,
  output logic             tx_data_out,
  output logic             tx_bit_clk_out,
  output logic             ref_clk_out,
  input  wire logic        supply_low_in,
  output logic             store_out,
  output logic             recall_out
);
  localparam int TX_BIT_CYC  = (`CCB_TX_BIT_NS + `CCB_CLK_NS - 1) / `CCB_CLK_NS;
  localparam int TX_HALF_CYC = TX_BIT_CYC / 2;

  ccb_pkg::ccb_tx_state_t tx_state_q;

  logic [15:0] ad_s1_q;
  logic [15:0] ad_s2_q;
  logic [1:0]  as_s_q;
  logic [1:0]  ds_s_q;
  logic [1:0]  rd_s_q;
  logic [1:0]  iack_s_q;
  logic        ds_prev_q;
  logic        iack_prev_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] vec_q;
  logic [2:0]  pend_q;
  logic [2:0]  pend_set_w;
  logic [2:0]  pend_clr_w;
  logic [1:0]  rx_bit_w;
  logic [1:0]  rx_frame_w;
  logic [1:0]  rx_req_w;
  logic        tx_en_q;
  logic        tx_bit_q;
  logic        tx_req_w;
  logic [9:0]  tx_cnt_q;
  logic [15:0] ref_acc_q;
  logic        ds_act_w;
  logic        ds_end_w;
  logic        iack_edge_w;
  logic        io_hit_w;
  logic        wr_txdata_w;
  logic        wr_txctrl_w;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Strobes come from another clock domain and pass two flip-flops.
  always_ff @(posedge core_clk_in) begin
    ad_s1_q  <= ad_in;
    ad_s2_q  <= ad_s1_q;
    as_s_q   <= {as_s_q[0], as_n_in};
    ds_s_q   <= {ds_s_q[0], ds_n_in};
    rd_s_q   <= {rd_s_q[0], read_in};
    iack_s_q <= {iack_s_q[0], iack_in};
  end

  assign ds_act_w    = !ds_s_q[1];
  assign ds_end_w    = ds_s_q[1] && !ds_prev_q;
  assign iack_edge_w = iack_s_q[1] && !iack_prev_q;
  assign io_hit_w    = in_range(addr_q, `CCB_IO_LO, `CCB_IO_HI);
  assign wr_txdata_w = ds_end_w && !rd_s_q[1] && (addr_q == `CCB_IO_TXDATA);
  assign wr_txctrl_w = ds_end_w && !rd_s_q[1] && (addr_q == `CCB_IO_TXCTRL);

  // Address phase while the address strobe is low; data phase under the data strobe.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      addr_q      <= 16'h0000;
      wdata_q     <= 16'h0000;
      ds_prev_q   <= 1'b1;
      iack_prev_q <= 1'b0;
    end else begin
      ds_prev_q   <= ds_s_q[1];
      iack_prev_q <= iack_s_q[1];
      if (!as_s_q[1]) begin
        addr_q <= ad_s2_q;
      end
      if (ds_act_w) begin
        wdata_q <= ad_s2_q;
      end
    end
  end

  // Selects stand only through the data phase of a matching address.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cs_mon_rom_out    <= 1'b0;
      cs_work_ram_out   <= 1'b0;
      cs_prog_rom_out   <= 1'b0;
      cs_shared_ram_out <= 1'b0;
    end else begin
      cs_mon_rom_out    <= ds_act_w && !iack_s_q[1] && in_range(addr_q, `CCB_MON_LO, `CCB_MON_HI);
      cs_work_ram_out   <= ds_act_w && !iack_s_q[1] && in_range(addr_q, `CCB_WORK_LO, `CCB_WORK_HI);
      cs_prog_rom_out   <= ds_act_w && !iack_s_q[1] && in_range(addr_q, `CCB_PROG_LO, `CCB_PROG_HI);
      cs_shared_ram_out <= ds_act_w && !iack_s_q[1] && in_range(addr_q, `CCB_SHARED_LO, `CCB_SHARED_HI);
    end
  end

  // Read data and vector fetch share the bus driver.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ad_out    <= 16'h0000;
      ad_oe_out <= 1'b0;
    end else begin
      ad_oe_out <= ds_act_w && rd_s_q[1] && (iack_s_q[1] || io_hit_w);
      if (iack_s_q[1]) begin
        ad_out <= vec_q;
      end else begin
        unique case (addr_q)
          `CCB_IO_RX0:    ad_out <= 16'({rx_frame_w[0], rx_bit_w[0]}) << `CCB_RX_DATA_BIT;
          `CCB_IO_RX1:    ad_out <= 16'({rx_frame_w[1], rx_bit_w[1]}) << `CCB_RX_DATA_BIT;
          `CCB_IO_TXCTRL: ad_out <= 16'(tx_en_q) << `CCB_TX_EN_BIT;
          default:        ad_out <= 16'h0000;
        endcase
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rx
      ccb_rx_port u_rx (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .bit_clk_in  (rx_bit_clk_in[gi]),
        .frame_in    (rx_frame_in[gi]),
        .data_in     (rx_data_in[gi]),
        .bit_out     (rx_bit_w[gi]),
        .frame_out   (rx_frame_w[gi]),
        .req_out     (rx_req_w[gi])
      );
    end
  endgenerate

  assign pend_set_w = {tx_req_w, rx_req_w};

  // The acknowledge takes the highest pending source and clears only that one.
  always_comb begin
    pend_clr_w = 3'h0;
    if (iack_edge_w) begin
      if (pend_q[`CCB_SRC_RX0]) begin
        pend_clr_w[`CCB_SRC_RX0] = 1'b1;
      end else if (pend_q[`CCB_SRC_RX1]) begin
        pend_clr_w[`CCB_SRC_RX1] = 1'b1;
      end else if (pend_q[`CCB_SRC_TX]) begin
        pend_clr_w[`CCB_SRC_TX] = 1'b1;
      end
    end
  end

  // A new request in the acknowledge cycle survives the clear.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pend_q  <= 3'h0;
      irq_out <= 1'b0;
      vec_q   <= `CCB_VEC_NONE;
    end else begin
      pend_q  <= (pend_q & ~pend_clr_w) | pend_set_w;
      irq_out <= |((pend_q & ~pend_clr_w) | pend_set_w);
      if (iack_edge_w) begin
        if (pend_q[`CCB_SRC_RX0]) begin
          vec_q <= `CCB_VEC_RX0;
        end else if (pend_q[`CCB_SRC_RX1]) begin
          vec_q <= `CCB_VEC_RX1;
        end else if (pend_q[`CCB_SRC_TX]) begin
          vec_q <= `CCB_VEC_TX;
        end else begin
          vec_q <= `CCB_VEC_NONE;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_en_q <= 1'b0;
    end else if (wr_txctrl_w) begin
      tx_en_q <= wdata_q[`CCB_TX_EN_BIT];
    end
  end

  // A bit written outside the ready state is dropped; only one bit per ready request is taken.
  assign tx_req_w = (tx_state_q == ccb_pkg::TX_OFF && tx_en_q) ||
                    (tx_state_q == ccb_pkg::TX_SEND && tx_cnt_q == 10'(TX_BIT_CYC - 1) && tx_en_q);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_state_q <= ccb_pkg::TX_OFF;
      tx_bit_q   <= 1'b0;
      tx_cnt_q   <= 10'h000;
    end else begin
      unique case (tx_state_q)
        ccb_pkg::TX_OFF: begin
          if (tx_en_q) begin
            tx_state_q <= ccb_pkg::TX_READY;
          end
        end
        ccb_pkg::TX_READY: begin
          if (!tx_en_q) begin
            tx_state_q <= ccb_pkg::TX_OFF;
          end else if (wr_txdata_w) begin
            tx_bit_q   <= wdata_q[`CCB_TX_DATA_BIT];
            tx_cnt_q   <= 10'h000;
            tx_state_q <= ccb_pkg::TX_SEND;
          end
        end
        ccb_pkg::TX_SEND: begin
          if (tx_cnt_q == 10'(TX_BIT_CYC - 1)) begin
            tx_cnt_q   <= 10'h000;
            tx_state_q <= tx_en_q ? ccb_pkg::TX_READY : ccb_pkg::TX_OFF;
          end else begin
            tx_cnt_q <= tx_cnt_q + 10'h001;
          end
        end
      endcase
    end
  end

  // The link outputs rest low whenever no bit is on its way out.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_data_out    <= 1'b0;
      tx_bit_clk_out <= 1'b0;
    end else begin
      tx_data_out    <= (tx_state_q == ccb_pkg::TX_SEND) && tx_bit_q;
      tx_bit_clk_out <= (tx_state_q == ccb_pkg::TX_SEND) && (tx_cnt_q < 10'(TX_HALF_CYC));
    end
  end

  // The reference is a phase accumulator, so its edges jitter by one core clock.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ref_acc_q   <= 16'h0000;
      ref_clk_out <= 1'b0;
    end else begin
      ref_acc_q   <= ref_acc_q + `CCB_REF_INC;
      ref_clk_out <= ref_acc_q[15];
    end
  end

  ccb_power_seq #(
    .RECALL_CYC (RECALL_CYC)
  ) u_power (
    .core_clk_in   (core_clk_in),
    .srst_in       (srst_in),
    .supply_low_in (supply_low_in),
    .store_out     (store_out),
    .recall_out    (recall_out)
  );

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_tx_ready;
    tx_state_q == ccb_pkg::TX_READY && tx_en_q && wr_txdata_w;
  endsequence
  sequence s_tx_bit_out;
    ##1 tx_state_q == ccb_pkg::TX_SEND ##1 tx_bit_clk_out;
  endsequence

  rx_request_a: assert property (rx_req_w[0] |=> pend_q[`CCB_SRC_RX0] && irq_out)
    else $error("Receiver bit did not raise a pending interrupt.");
  ack_priority_a: assert property (iack_edge_w && pend_q[`CCB_SRC_RX0] |=> vec_q == `CCB_VEC_RX0 && pend_q[`CCB_SRC_TX] == $past(pend_q[`CCB_SRC_TX] | tx_req_w))
    else $error("Acknowledge did not favour the first receiver.");
  vector_drive_a: assert property (iack_s_q[1] && ds_act_w && rd_s_q[1] |=> ad_oe_out && ad_out == $past(vec_q))
    else $error("Vector not driven during acknowledge.");
  tx_idle_a: assert property (tx_state_q == ccb_pkg::TX_OFF ##1 tx_state_q == ccb_pkg::TX_OFF |-> !tx_data_out && !tx_bit_clk_out)
    else $error("Downlink active while not enabled.");
  tx_one_bit_a: assert property (s_tx_ready |-> s_tx_bit_out)
    else $error("Written bit did not start a transmission.");
  tx_next_req_a: assert property (tx_state_q == ccb_pkg::TX_SEND && tx_cnt_q == 10'(TX_BIT_CYC - 1) && tx_en_q |=> pend_q[`CCB_SRC_TX] && tx_state_q == ccb_pkg::TX_READY)
    else $error("No ready request after a sent bit.");
  cs_onehot_a: assert property ($onehot0({cs_mon_rom_out, cs_work_ram_out, cs_prog_rom_out, cs_shared_ram_out}))
    else $error("More than one chip select active.");
  shared_sel_a: assert property (ds_act_w && !iack_s_q[1] && addr_q == `CCB_SHARED_LO |=> cs_shared_ram_out && !ad_oe_out)
    else $error("Shared range not decoded off card.");
endmodule

// File: dv/ccb_fsk_model.sv
`timescale 1ns/1ns

// Both uplink receivers and the downlink listener; the bit clock only runs while a bit is sent.
module ccb_fsk_model (
  output logic [1:0] rx_bit_clk_out,
  output logic [1:0] rx_frame_out,
  output logic [1:0] rx_data_out,
  input  wire logic  tx_data_in,
  input  wire logic  tx_bit_clk_in,
  input  wire logic  store_in,
  input  wire logic  recall_in
);
  logic        tx_bits_q[$];
  logic [15:0] shadow_vol_q;
  logic [15:0] shadow_nv_q;

  initial begin
    rx_bit_clk_out = 2'h0;
    rx_frame_out = 2'h0;
    rx_data_out = 2'h0;
    shadow_vol_q = 16'h0000;
    shadow_nv_q = 16'hC35A;
  end

  // One word stands for the whole shadow memory; a copy on the rising edge of each pulse is enough here.
  always @(posedge store_in) begin
    shadow_nv_q = shadow_vol_q;
  end

  always @(posedge recall_in) begin
    shadow_vol_q = shadow_nv_q;
  end

  task automatic write_word(input logic [15:0] w);
    shadow_vol_q = w;
  endtask

  // One 125 ns bit; data and marker settle well before the clock rises.
  task automatic send_bit(input int rx, input logic frame, input logic data);
    rx_data_out[rx] = data;
    rx_frame_out[rx] = frame;
    #31;
    rx_bit_clk_out[rx] = 1'b1;
    #62;
    rx_bit_clk_out[rx] = 1'b0;
    #32;
    // Hold time is over, so the lines show the opposite value rather than a stale bit.
    rx_data_out[rx] = ~data;
    rx_frame_out[rx] = ~frame;
  endtask

  always @(posedge tx_bit_clk_in) begin
    #1;
    tx_bits_q.push_back(tx_data_in);
  end
endmodule

// File: dv/test_comm_card_bit_link_interface.sv
`timescale 1ns/1ns
`include "ccb_regs.svh"

module test_comm_card_bit_link_interface;
  localparam logic [15:0] DEC_ADDR [12] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h2000, 16'h3FFF, 16'h4000,
                                           16'h47FF, 16'h4800, 16'h5000, 16'h7FFF, 16'h8000, 16'hFFFF};
  localparam logic [3:0]  DEC_CS [12]   = '{4'h8, 4'h8, 4'h0, 4'h4, 4'h4, 4'h2,
                                           4'h2, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1};
  logic        core_clk_in   = 1'b0;
  logic        srst_in       = 1'b1;
  logic [15:0] ad_in         = 16'h0000;
  logic        as_n_in       = 1'b1;
  logic        ds_n_in       = 1'b1;
  logic        read_in       = 1'b0;
  logic        iack_in       = 1'b0;
  logic        supply_low_in = 1'b0;
  logic [15:0] ad_out;
  logic        ad_oe_out;
  logic        irq_out;
  logic        cs_mon_rom_out;
  logic        cs_work_ram_out;
  logic        cs_prog_rom_out;
  logic        cs_shared_ram_out;
  logic [1:0]  rx_bit_clk_in;
  logic [1:0]  rx_frame_in;
  logic [1:0]  rx_data_in;
  logic        tx_data_out;
  logic        tx_bit_clk_out;
  logic        ref_clk_out;
  logic        store_out;
  logic        recall_out;
  logic [3:0]  cs;
  logic [15:0] rdata;
  logic        oe;
  int          errors = 0;
  int          checks = 0;

  always #5 core_clk_in = ~core_clk_in;

  ccb_comm_card #(.RECALL_CYC(50)) uut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_out(ad_oe_out),
    .as_n_in(as_n_in), .ds_n_in(ds_n_in), .read_in(read_in), .iack_in(iack_in), .irq_out(irq_out),
    .cs_mon_rom_out(cs_mon_rom_out), .cs_work_ram_out(cs_work_ram_out), .cs_prog_rom_out(cs_prog_rom_out),
    .cs_shared_ram_out(cs_shared_ram_out), .rx_bit_clk_in(rx_bit_clk_in), .rx_frame_in(rx_frame_in),
    .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .tx_bit_clk_out(tx_bit_clk_out),
    .ref_clk_out(ref_clk_out), .supply_low_in(supply_low_in), .store_out(store_out), .recall_out(recall_out)
  );

  ccb_fsk_model fsk (
    .rx_bit_clk_out(rx_bit_clk_in), .rx_frame_out(rx_frame_in), .rx_data_out(rx_data_in),
    .tx_data_in(tx_data_out), .tx_bit_clk_in(tx_bit_clk_out), .store_in(store_out), .recall_in(recall_out)
  );

  task automatic give_verdict;
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address phase, then data phase; each phase is held long enough to pass the synchronisers.
  task automatic bus(input logic [15:0] addr, input logic rd, input logic [15:0] wd, input logic ack);
    @(negedge core_clk_in);
    ad_in = addr;
    read_in = rd;
    iack_in = ack;
    as_n_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    as_n_in = 1'b1;
    @(negedge core_clk_in);
    ds_n_in = 1'b0;
    if (!rd) ad_in = wd;
    repeat (6) @(negedge core_clk_in);
    cs = {cs_mon_rom_out, cs_work_ram_out, cs_shared_ram_out, cs_prog_rom_out};
    rdata = ad_out;
    oe = ad_oe_out;
    ds_n_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    iack_in = 1'b0;
  endtask

  task automatic service(input logic [15:0] vec);
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 900) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("irq_out raised", 16'h1, {15'h0, irq_out});
    bus(16'h0000, 1'b1, 16'h0000, 1'b1);
    chk("vector", vec, rdata);
    chk("vector driven", 16'h1, {15'h0, oe});
    chk("selects in fetch", 16'h0, {12'h0, cs});
  endtask

  task automatic t_power;
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    chk("recall_out at release", 16'h1, {15'h0, recall_out});
    supply_low_in = 1'b1;
    while (recall_out === 1'b1 && n < 200) begin
      @(negedge core_clk_in);
      seen = seen | store_out;
      n++;
    end
    chk("recall length ok", 16'h1, {15'h0, n >= 48 && n <= 52});
    chk("store during recall", 16'h0, {15'h0, seen});
    chk("shadow reloaded", 16'hC35A, fsk.shadow_vol_q);
    supply_low_in = 1'b0;
    fsk.write_word(16'h3CA5);
    repeat (8) @(negedge core_clk_in);
    supply_low_in = 1'b1;
    n = 0;
    while (store_out !== 1'b1 && n < 10) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("store start", 16'h0003, n[15:0]);
    n = 0;
    while (store_out === 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    chk("store length", 16'h00C8, n[15:0]);
    chk("shadow stored", 16'h3CA5, fsk.shadow_nv_q);
    supply_low_in = 1'b0;
  endtask

  task automatic t_decode;
    for (int i = 0; i < 12; i++) begin
      bus(DEC_ADDR[i], 1'b1, 16'h0000, 1'b0);
      chk("read selects", {12'h0, DEC_CS[i]}, {12'h0, cs});
    end
    bus(16'h3000, 1'b0, 16'hA5A5, 1'b0);
    chk("write selects", 16'h0004, {12'h0, cs});
  endtask

  task automatic t_rx;
    logic [15:0] exp;
    logic [3:0]  bits;
    for (int r = 0; r < 2; r++) begin
      bits = r == 0 ? 4'hB : 4'h4;
      for (int b = 0; b < 4; b++) begin
        fsk.send_bit(r, b == 0, bits[b]);
        service(r == 0 ? `CCB_VEC_RX0 : `CCB_VEC_RX1);
        chk("irq after ack", 16'h0, {15'h0, irq_out});
        bus(r == 0 ? `CCB_IO_RX0 : `CCB_IO_RX1, 1'b1, 16'h0000, 1'b0);
        exp = 16'h0000;
        exp[`CCB_RX_DATA_BIT] = bits[b];
        exp[`CCB_RX_FRAME_BIT] = b == 0;
        chk("rx port word", exp, rdata);
      end
    end
  endtask

  task automatic t_prio;
    fork
      fsk.send_bit(0, 1'b0, 1'b1);
      fsk.send_bit(1, 1'b0, 1'b0);
    join
    repeat (30) @(negedge core_clk_in);
    service(`CCB_VEC_RX0);
    service(`CCB_VEC_RX1);
    chk("irq after both", 16'h0, {15'h0, irq_out});
  endtask

  task automatic t_tx;
    logic [2:0] pat;
    pat = 3'h5;
    // A bit written before the port is enabled must never reach the line.
    bus(`CCB_IO_TXDATA, 1'b0, 16'h0001, 1'b0);
    repeat (20) @(negedge core_clk_in);
    chk("tx idle data", 16'h0, {15'h0, tx_data_out});
    chk("tx idle irq", 16'h0, {15'h0, irq_out});
    bus(`CCB_IO_TXCTRL, 1'b0, 16'h0001, 1'b0);
    bus(`CCB_IO_TXCTRL, 1'b1, 16'h0000, 1'b0);
    chk("tx enable readback", 16'h0001, rdata);
    for (int i = 0; i < 3; i++) begin
      service(`CCB_VEC_TX);
      bus(`CCB_IO_TXDATA, 1'b0, {15'h0, pat[i]}, 1'b0);
      repeat (300) @(negedge core_clk_in);
      chk("tx bit on line", {15'h0, pat[i]}, {15'h0, tx_data_out});
      chk("no request mid bit", 16'h0, {15'h0, irq_out});
    end
    service(`CCB_VEC_TX);
    bus(`CCB_IO_TXCTRL, 1'b0, 16'h0000, 1'b0);
    repeat (1000) @(negedge core_clk_in);
    chk("tx off irq", 16'h0, {15'h0, irq_out});
    chk("tx off data", 16'h0, {15'h0, tx_data_out});
    chk("tx bit count", 16'h3, 16'(fsk.tx_bits_q.size()));
    for (int i = 0; i < 3; i++) begin
      chk("tx bit seen", {15'h0, pat[i]}, {15'h0, fsk.tx_bits_q[i]});
    end
  endtask

  task automatic t_ref;
    int   n;
    logic prev;
    n = 0;
    prev = ref_clk_out;
    repeat (1000) begin
      @(negedge core_clk_in);
      if (ref_clk_out === 1'b1 && prev === 1'b0) n++;
      prev = ref_clk_out;
    end
    chk("ref edges in 10 us", 16'h1, {15'h0, n >= 318 && n <= 322});
  endtask

  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(negedge core_clk_in);
    srst_in = 1'b0;
    t_power();
    t_decode();
    t_rx();
    t_prio();
    t_tx();
    t_ref();
    give_verdict();
  end
endmodule
